// [pkg/ldb_pkg.sv]
`default_nettype none
package ldb_pkg;
    localparam int HOST_W = 64;
    localparam int PCI_W = 32;
    localparam int BYTE_W = 8;
    localparam int PAR_W = HOST_W / BYTE_W;
    localparam int HP_LEVELS = 4;
    localparam int HP_DW_PER_LEVEL = 4;
    localparam int HP_DEPTH = HP_LEVELS * HP_DW_PER_LEVEL;
    localparam int HM_DEPTH = 4;
    localparam int STEP_W = 3;
    // Nominal bus clocks; the whole block runs on the 100 MHz core clock.
    localparam int CORE_CLK_KHZ = 100000;
    localparam int HOST_CLK_KHZ = 66700;
    localparam int PCI_CLK_KHZ = 33300;
    // Last push step and last pop step of a four-quadword line write.
    localparam logic [STEP_W-1:0] STEP_LINE_LAST = 3'h3;
    localparam logic [STEP_W-1:0] STEP_DRAIN_LAST = 3'h7;

    typedef enum logic [2:0] {
        CMD_HOST_WR_MEM = 3'h0,
        CMD_HOST_RD_MEM = 3'h1,
        CMD_HOST_WR_PCI = 3'h2,
        CMD_HOST_WR_IO = 3'h3,
        CMD_HOST_RD_PCI = 3'h4,
        CMD_PCI_RD_MEM = 3'h5,
        CMD_PCI_RD_L2 = 3'h6,
        CMD_PCI_WR_MEM = 3'h7
    } ldb_cmd_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_RUN = 3'h2,
        ST_DONE = 3'h4
    } ldb_cst_t;

    typedef enum logic [2:0] {
        WAIT_NONE = 3'h0,
        WAIT_HP_ROOM = 3'h1,
        WAIT_HM_ROOM = 3'h2,
        WAIT_HP_EMPTY = 3'h3,
        WAIT_HM_DATA = 3'h4
    } ldb_wait_t;

    typedef struct packed {
        logic hp_push;
        logic hp_hi;
        logic hp_pop;
        logic hm_push;
        logic hm_pop;
        logic mem_latch;
        logic pr_latch;
        logic pr_from_host;
        logic pr_upper;
        logic pm_latch;
        logic pm_upper;
        logic pm_to_mem;
        logic host_oe;
        logic host_from_pm;
        logic pci_bus_output_enable;
    } ldb_strobe_t;
endpackage
`default_nettype wire

// [pkg/ldb_if.sv]
`default_nettype none
interface ldb_if;
    ldb_pkg::ldb_strobe_t strb;
    logic hp_ready;
    logic hp_has_data;
    logic hm_ready;
    logic hm_has_data;
    modport dev (
        input strb,
        output hp_ready, hp_has_data, hm_ready, hm_has_data
    );
    modport ctrl (
        output strb,
        input hp_ready, hp_has_data, hm_ready, hm_has_data
    );
endinterface
`default_nettype wire

// [verilog/ldb_fifo.sv]
`default_nettype none
module ldb_fifo #(
    parameter int W = 32, // Word width.
    parameter int D = 32 // Depth in words.
) (
    input wire logic core_clk, // Core clock.
    input wire logic nrst, // Async reset, active low.
    input wire logic in_valid, // Word offered.
    output logic in_ready, // Room for a word.
    input wire logic [W-1:0] in_data, // Word in.
    output logic out_valid, // Word waiting.
    input wire logic out_ready, // Word taken.
    output logic [W-1:0] out_data // Oldest word.
);
    localparam int AW = (D > 1) ? $clog2(D) : 1;
    localparam int CW = $clog2(D + 1);
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [CW-1:0] cnt;
        logic full;
        logic has_data;
    } ldb_fifo_st_t;
    ldb_fifo_st_t s_r;
    ldb_fifo_st_t s_nxt;
    logic wr;
    logic rd;

    // A full buffer refuses the word rather than overwrite the oldest.
    assign wr = in_valid & ~s_r.full;
    assign rd = out_ready & s_r.has_data;

    always_comb begin
        s_nxt = s_r;
        if (wr) begin
            s_nxt.mem[s_r.wp] = in_data;
            s_nxt.wp = (s_r.wp == AW'(D - 1)) ? '0 : s_r.wp + 1'b1;
        end
        if (rd) begin
            s_nxt.rp = (s_r.rp == AW'(D - 1)) ? '0 : s_r.rp + 1'b1;
        end
        s_nxt.cnt = s_r.cnt + CW'(wr) - CW'(rd);
        s_nxt.full = (s_nxt.cnt == CW'(D));
        s_nxt.has_data = (s_nxt.cnt != '0);
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Flags come from flip-flops so a producer never sees a glitchy level.
    assign in_ready = ~s_r.full;
    assign out_valid = s_r.has_data;
    assign out_data = s_r.mem[s_r.rp];
endmodule
`default_nettype wire

// [verilog/ldb_buffer.sv]
// What this block does
// - Buffer data among host, memory, PCI buses.
// - Run synchronously on the 100 MHz core clock.
// - Host-to-PCI buffer: four levels, sixteen doublewords.
// - Host-to-memory buffer holds four quadwords.
// - PCI-to-memory buffer holds one quadword.
// - Latch memory read quadword before host.
// - Latch PCI reads of memory one quadword.
// - Move data only under controller strobes.
// - Host memory writes pushed, later popped out.
// - Check parity on host memory reads.
// - Generate parity on every memory write.
// - Ignore parity on memory reads for PCI.
// - Host PCI writes posted, drained when free.
// - Controller holds writes while buffer full.
// - I/O writes use buffer, complete after drain.
// - PCI read of dirty line from host.
// - Controller waits one state per doubleword.
// - Host read of PCI waits for drain.
// - Assemble PCI read doublewords before host.
// - PCI writes posted, to memory, and to host on a cache hit.
// - Drive PCI bus only while enabled.
// - Flag memory parity error active low.
`default_nettype none
module ldb_buffer (
    input wire logic core_clk, // Core clock, 100 MHz.
    input wire logic nrst, // Async reset, active low.
    ldb_if.dev lnk, // Strobes and buffer status.
    input wire logic [ldb_pkg::HOST_W-1:0] host_data_bus_in, // Host in.
    output logic [ldb_pkg::HOST_W-1:0] host_data_bus_out, // Host out.
    output logic host_data_bus_oe, // Drive host bus.
    input wire logic [ldb_pkg::HOST_W-1:0] memory_data_bus_in, // Mem in.
    output logic [ldb_pkg::HOST_W-1:0] memory_data_bus_out, // Mem out.
    output logic memory_data_bus_oe, // Drive memory bus.
    input wire logic [ldb_pkg::PAR_W-1:0] memory_parity_bus_in, // Par in.
    output logic [ldb_pkg::PAR_W-1:0] memory_parity_bus_out, // Par out.
    output logic memory_parity_bus_oe, // Drive parity bus.
    input wire logic [ldb_pkg::PCI_W-1:0] pci_ad_in, // PCI AD in.
    output logic [ldb_pkg::PCI_W-1:0] pci_ad_out, // PCI AD out.
    output logic pci_ad_oe, // Drive PCI AD bus.
    output logic parity_err_n // Memory read parity error, low.
);
    localparam int HW = ldb_pkg::HOST_W;
    localparam int PW = ldb_pkg::PCI_W;
    localparam int QW = ldb_pkg::PAR_W;

    // Every register of this end sits in one struct, so reset and the
    // next-state copy can never miss a field.
    typedef struct packed {
        logic [HW-1:0] host_read_buffer;
        logic [HW-1:0] pci_read_buffer;
        logic [HW-1:0] pci_to_mem_post_buffer;
        logic [HW-1:0] host_out;
        logic [HW-1:0] mem_out;
        logic [QW-1:0] par_out;
        logic [PW-1:0] ad_out;
        logic host_oe;
        logic mem_oe;
        logic ad_oe;
        logic par_err_n;
    } ldb_dev_st_t;

    // The error flag idles high: no error until a read proves one.
    localparam ldb_dev_st_t DEV_RST = '{par_err_n: 1'b1, default: '0};

    ldb_dev_st_t s_r;
    ldb_dev_st_t s_nxt;
    ldb_pkg::ldb_strobe_t st;
    logic [PW-1:0] hp_in;
    logic [PW-1:0] hp_data;
    logic hp_valid;
    logic [HW-1:0] hm_data;
    logic hm_valid;
    logic hm_take;
    logic [QW-1:0] rd_bad;

    // Even parity per byte lane of a quadword.
    function automatic logic [QW-1:0] par_of(input logic [HW-1:0] d);
        logic [QW-1:0] p;
        p = '0;
        for (int i = 0; i < QW; i++) begin
            p[i] = ^d[i*ldb_pkg::BYTE_W +: ldb_pkg::BYTE_W];
        end
        return p;
    endfunction

    assign st = lnk.strb;
    assign hp_in = st.hp_hi ? host_data_bus_in[HW-1:PW]
                            : host_data_bus_in[PW-1:0];
    assign hp_valid = lnk.hp_has_data;
    assign hm_valid = lnk.hm_has_data;
    assign hm_take = st.hm_pop & hm_valid;
    // Parity is checked on the raw memory bus in the latch cycle; a read
    // meant for PCI never looks at the result, so it cannot raise the flag.
    assign rd_bad = par_of(memory_data_bus_in) ^ memory_parity_bus_in;

    ldb_fifo #(
        .W(PW),
        .D(ldb_pkg::HP_DEPTH)
    ) u_host_to_pci_post_buffer (
        .core_clk(core_clk),
        .nrst(nrst),
        .in_valid(st.hp_push),
        .in_ready(lnk.hp_ready),
        .in_data(hp_in),
        .out_valid(lnk.hp_has_data),
        .out_ready(st.hp_pop),
        .out_data(hp_data)
    );

    ldb_fifo #(
        .W(HW),
        .D(ldb_pkg::HM_DEPTH)
    ) u_host_to_mem_post_buffer (
        .core_clk(core_clk),
        .nrst(nrst),
        .in_valid(st.hm_push),
        .in_ready(lnk.hm_ready),
        .in_data(host_data_bus_in),
        .out_valid(lnk.hm_has_data),
        .out_ready(st.hm_pop),
        .out_data(hm_data)
    );

    always_comb begin
        s_nxt = s_r;
        s_nxt.host_oe = st.host_oe;
        s_nxt.mem_oe = hm_take | st.pm_to_mem;
        s_nxt.ad_oe = st.pci_bus_output_enable;
        if (st.mem_latch) begin
            s_nxt.host_read_buffer = memory_data_bus_in;
            // active-low error flag
            // The flag stands until the next host read latch, so a later
            // clean read hides an earlier error from anyone who looks late.
            s_nxt.par_err_n = ~|rd_bad;
        end
        if (st.pr_latch) begin
            s_nxt.pci_read_buffer = st.pr_from_host ? host_data_bus_in
                                                    : memory_data_bus_in;
        end
        if (st.pm_latch) begin
            if (st.pm_upper) begin
                s_nxt.pci_to_mem_post_buffer[HW-1:PW] = pci_ad_in;
            end else begin
                s_nxt.pci_to_mem_post_buffer[PW-1:0] = pci_ad_in;
            end
        end
        if (st.host_oe) begin
            s_nxt.host_out = st.host_from_pm ? s_r.pci_to_mem_post_buffer
                                             : s_r.host_read_buffer;
        end
        // The line buffer wins if both sources are strobed together.
        if (hm_take) begin
            s_nxt.mem_out = hm_data;
        end else if (st.pm_to_mem) begin
            s_nxt.mem_out = s_r.pci_to_mem_post_buffer;
        end
        s_nxt.par_out = par_of(s_nxt.mem_out);
        // drive only when enabled
        // A drain pop takes the bus ahead of a read delivery. The
        // controller keeps drains off during PCI reads, so the two never
        // meet in practice; the order only settles a misbehaving strobe.
        if (st.hp_pop & hp_valid) begin
            s_nxt.ad_out = hp_data;
        end else if (st.pci_bus_output_enable) begin
            s_nxt.ad_out = st.pr_upper ? s_r.pci_read_buffer[HW-1:PW]
                                       : s_r.pci_read_buffer[PW-1:0];
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            s_r <= DEV_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign host_data_bus_out = s_r.host_out;
    assign host_data_bus_oe = s_r.host_oe;
    assign memory_data_bus_out = s_r.mem_out;
    assign memory_data_bus_oe = s_r.mem_oe;
    assign memory_parity_bus_out = s_r.par_out;
    assign memory_parity_bus_oe = s_r.mem_oe;
    assign pci_ad_out = s_r.ad_out;
    assign pci_ad_oe = s_r.ad_oe;
    assign parity_err_n = s_r.par_err_n;
endmodule
`default_nettype wire

// [verilog/ldb_ctrl.sv]
`default_nettype none
module ldb_ctrl (
    input wire logic core_clk, // Core clock, 100 MHz.
    input wire logic nrst, // Async reset, active low.
    ldb_if.ctrl lnk, // Strobes to the data buffer.
    input wire logic cmd_valid, // Transfer requested.
    input wire ldb_pkg::ldb_cmd_t cmd_code, // Transfer kind.
    input wire logic cmd_l2_hit, // PCI write also hits cache.
    input wire logic pci_free, // PCI bus free for posted data.
    output logic cmd_ready, // Ready for a transfer.
    output logic cmd_done // Transfer complete, one cycle.
);
    typedef struct packed {
        ldb_pkg::ldb_strobe_t strb;
        ldb_pkg::ldb_wait_t wt;
        logic last;
    } ldb_step_t;

    typedef struct packed {
        ldb_pkg::ldb_cst_t st;
        ldb_pkg::ldb_cmd_t code;
        logic hit;
        logic [ldb_pkg::STEP_W-1:0] step;
        logic gap;
        logic dgap;
        ldb_pkg::ldb_strobe_t strb;
        logic ready;
        logic done;
    } ldb_ctl_st_t;

    localparam ldb_ctl_st_t CTL_RST = '{st: ldb_pkg::ST_IDLE,
        code: ldb_pkg::CMD_HOST_WR_MEM, default: '0};

    ldb_ctl_st_t s_r;
    ldb_ctl_st_t s_nxt;
    ldb_step_t p;
    logic go;
    logic pci_busy;

    function automatic ldb_step_t plan(input ldb_pkg::ldb_cmd_t c,
                                       input logic [2:0] k,
                                       input logic hit);
        ldb_step_t q;
        q = '{strb: '0, wt: ldb_pkg::WAIT_NONE, last: 1'b0};
        case (c)
            ldb_pkg::CMD_HOST_WR_MEM: begin
                if (k <= ldb_pkg::STEP_LINE_LAST) begin
                    q.strb.hm_push = 1'b1;
                    q.wt = ldb_pkg::WAIT_HM_ROOM;
                end else begin
                    q.strb.hm_pop = 1'b1;
                    q.wt = ldb_pkg::WAIT_HM_DATA;
                end
                q.last = (k == ldb_pkg::STEP_DRAIN_LAST);
            end
            ldb_pkg::CMD_HOST_RD_MEM: begin
                q.strb.mem_latch = (k == 3'h0);
                q.strb.host_oe = (k != 3'h0);
                q.last = (k != 3'h0);
            end
            ldb_pkg::CMD_HOST_WR_PCI, ldb_pkg::CMD_HOST_WR_IO: begin
                q.strb.hp_push = (k != 3'h2);
                q.strb.hp_hi = (k == 3'h1);
                q.wt = ldb_pkg::WAIT_HP_ROOM;
                q.last = (c == ldb_pkg::CMD_HOST_WR_PCI) && (k == 3'h1);
                if (k == 3'h2) begin
                    q.wt = ldb_pkg::WAIT_HP_EMPTY;
                    q.last = 1'b1;
                end
            end
            ldb_pkg::CMD_HOST_RD_PCI: begin
                q.wt = (k == 3'h0) ? ldb_pkg::WAIT_HP_EMPTY
                                   : ldb_pkg::WAIT_NONE;
                q.strb.pm_latch = (k == 3'h1) || (k == 3'h2);
                q.strb.pm_upper = (k == 3'h2);
                q.strb.host_oe = (k == 3'h3);
                q.strb.host_from_pm = (k == 3'h3);
                q.last = (k == 3'h3);
            end
            ldb_pkg::CMD_PCI_RD_MEM, ldb_pkg::CMD_PCI_RD_L2: begin
                q.strb.pr_latch = (k == 3'h0);
                q.strb.pr_from_host = (c == ldb_pkg::CMD_PCI_RD_L2);
                q.strb.pci_bus_output_enable = (k == 3'h1) || (k == 3'h3);
                q.strb.pr_upper = (k == 3'h3);
                q.last = (k == 3'h3);
            end
            default: begin
                q.strb.pm_latch = (k == 3'h0) || (k == 3'h1);
                q.strb.pm_upper = (k == 3'h1);
                q.strb.pm_to_mem = (k == 3'h2);
                q.strb.host_oe = (k == 3'h3);
                q.strb.host_from_pm = (k == 3'h3);
                q.last = ((k == 3'h2) && !hit) || (k == 3'h3);
            end
        endcase
        return q;
    endfunction

    assign p = plan(s_r.code, s_r.step, s_r.hit);
    assign pci_busy = (s_r.st != ldb_pkg::ST_IDLE) &&
        ((s_r.code inside {ldb_pkg::CMD_PCI_RD_MEM, ldb_pkg::CMD_PCI_RD_L2,
                           ldb_pkg::CMD_PCI_WR_MEM}) ||
         ((s_r.code == ldb_pkg::CMD_HOST_RD_PCI) && (s_r.step != '0)));

    always_comb begin
        case (p.wt)
            ldb_pkg::WAIT_HP_ROOM: go = lnk.hp_ready;
            ldb_pkg::WAIT_HM_ROOM: go = lnk.hm_ready;
            ldb_pkg::WAIT_HP_EMPTY: go = ~lnk.hp_has_data;
            ldb_pkg::WAIT_HM_DATA: go = lnk.hm_has_data;
            default: go = 1'b1;
        endcase
    end

    // Each strobe is followed by a quiet cycle so the buffer flags seen at
    // the next decision already include it; this halves the rate.
    always_comb begin
        s_nxt = s_r;
        s_nxt.strb = '0;
        s_nxt.done = 1'b0;
        s_nxt.gap = 1'b0;
        case (s_r.st)
            ldb_pkg::ST_IDLE: begin
                if (cmd_valid && s_r.ready) begin
                    s_nxt.code = cmd_code;
                    s_nxt.hit = cmd_l2_hit;
                    s_nxt.step = '0;
                    s_nxt.st = ldb_pkg::ST_RUN;
                end
            end
            ldb_pkg::ST_RUN: begin
                if (!s_r.gap && go) begin
                    s_nxt.strb = p.strb;
                    s_nxt.gap = 1'b1;
                    if (p.last) begin
                        s_nxt.st = ldb_pkg::ST_DONE;
                    end else begin
                        s_nxt.step = s_r.step + 1'b1;
                    end
                end
            end
            ldb_pkg::ST_DONE: begin
                s_nxt.done = 1'b1;
                s_nxt.st = ldb_pkg::ST_IDLE;
            end
            default: s_nxt.st = ldb_pkg::ST_IDLE;
        endcase
        s_nxt.dgap = 1'b0;
        if (!pci_busy && pci_free && lnk.hp_has_data && !s_r.dgap) begin
            s_nxt.strb.hp_pop = 1'b1;
            s_nxt.strb.pci_bus_output_enable = 1'b1;
            s_nxt.dgap = 1'b1;
        end
        s_nxt.ready = (s_nxt.st == ldb_pkg::ST_IDLE);
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            s_r <= CTL_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign lnk.strb = s_r.strb;
    assign cmd_ready = s_r.ready;
    assign cmd_done = s_r.done;
endmodule
`default_nettype wire

// [tb/ldb_assertions.sv]
`default_nettype none
module ldb_assertions (
    input wire logic core_clk, // Core clock.
    input wire logic nrst, // Async reset, active low.
    input wire ldb_pkg::ldb_strobe_t strb, // Controller strobes.
    input wire logic hp_ready, // Host-to-PCI room.
    input wire logic hp_has_data, // Host-to-PCI data held.
    input wire logic hm_ready, // Host-to-memory room.
    input wire logic hm_has_data // Host-to-memory data held.
);
    timeunit 1ns;
    timeprecision 1ps;

    // Occupancy is rebuilt from the strobes, so the flags can be judged
    // against the fixed depths rather than against themselves.
    int hp_cnt_r;
    int hm_cnt_r;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            hp_cnt_r <= 0;
            hm_cnt_r <= 0;
        end else begin
            hp_cnt_r <= hp_cnt_r + int'(strb.hp_push && hp_ready)
                - int'(strb.hp_pop && hp_has_data);
            hm_cnt_r <= hm_cnt_r + int'(strb.hm_push && hm_ready)
                - int'(strb.hm_pop && hm_has_data);
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);

    hp_depth_a: assert property (hp_ready == (hp_cnt_r < ldb_pkg::HP_DEPTH))
        else $error("host-to-PCI room flag disagrees with fill");
    hp_data_a: assert property (hp_has_data == (hp_cnt_r != 0))
        else $error("host-to-PCI data flag disagrees with fill");
    hm_depth_a: assert property (hm_ready == (hm_cnt_r < ldb_pkg::HM_DEPTH))
        else $error("host-to-memory room flag disagrees with fill");
    hm_data_a: assert property (hm_has_data == (hm_cnt_r != 0))
        else $error("host-to-memory data flag disagrees with fill");
    hp_full_hold_a: assert property (!hp_ready |-> !strb.hp_push)
        else $error("push into full host-to-PCI buffer");
    hm_pop_data_a: assert property (strb.hm_pop |-> hm_has_data)
        else $error("pop from empty host-to-memory buffer");
    drain_drive_a: assert property (strb.hp_pop
        |-> strb.pci_bus_output_enable && hp_has_data)
        else $error("drain without PCI drive enable");
    wait_state_a: assert property (strb.pci_bus_output_enable
        && !strb.hp_pop && !strb.pr_upper
        |=> !strb.pci_bus_output_enable [*3] ##1 strb.pr_upper)
        else $error("no wait state before upper doubleword");
    latch_gap_a: assert property (strb.mem_latch |=> !strb.mem_latch)
        else $error("memory latch strobe longer than one cycle");
endmodule
`default_nettype wire

// [tb/tb_host_memory_pci_data_buffer.sv]
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin errors++; \
    $display("[ERR] %0t: value mismatch", $time); end end
module tb_host_memory_pci_data_buffer;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [63:0] H_STEP = 64'h0101_0101_0101_0101;
    localparam logic [31:0] A_STEP = 32'h1111_1111;
    localparam logic [63:0] M_VAL = 64'hfedc_ba98_7654_3210;
    logic core_clk, nrst, cmd_valid, cmd_l2_hit, pci_free;
    logic cmd_ready, cmd_done, h_oe, m_oe, mp_oe, a_oe, perr_n;
    ldb_pkg::ldb_cmd_t cmd_code;
    logic [63:0] h_in, h_out, m_in, m_out;
    logic [7:0] mp_in, mp_out;
    logic [31:0] a_in, a_out;
    logic [63:0] exp_h[$], exp_m[$];
    logic [31:0] exp_a[$];
    int errors = 0;
    int n_tests = 0;

    ldb_if lnk();
    ldb_buffer ldb_buffer_inst (.core_clk(core_clk), .nrst(nrst), .lnk(lnk),
        .host_data_bus_in(h_in), .host_data_bus_out(h_out),
        .host_data_bus_oe(h_oe), .memory_data_bus_in(m_in),
        .memory_data_bus_out(m_out), .memory_data_bus_oe(m_oe),
        .memory_parity_bus_in(mp_in), .memory_parity_bus_out(mp_out),
        .memory_parity_bus_oe(mp_oe), .pci_ad_in(a_in), .pci_ad_out(a_out),
        .pci_ad_oe(a_oe), .parity_err_n(perr_n));
    ldb_ctrl ldb_ctrl_inst (.core_clk(core_clk), .nrst(nrst), .lnk(lnk),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_l2_hit(cmd_l2_hit),
        .pci_free(pci_free), .cmd_ready(cmd_ready), .cmd_done(cmd_done));
    ldb_assertions ldb_assertions_inst (.core_clk(core_clk), .nrst(nrst),
        .strb(lnk.strb), .hp_ready(lnk.hp_ready),
        .hp_has_data(lnk.hp_has_data), .hm_ready(lnk.hm_ready),
        .hm_has_data(lnk.hm_has_data));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    function automatic logic [7:0] par(input logic [63:0] d);
        for (int i = 0; i < 8; i++)
            par[i] = ^d[8*i +: 8];
    endfunction

    // Fresh data after every line push and PCI write latch makes each beat distinguishable.
    always @(posedge core_clk) begin
        if (lnk.strb.hm_push === 1'b1)
            h_in <= h_in + H_STEP;
        if (lnk.strb.pm_latch === 1'b1)
            a_in <= a_in + A_STEP;
    end

    always @(posedge core_clk) begin
        if (a_oe === 1'b1) begin
            if (exp_a.size() == 0)
                `CHK(a_oe, 1'b0)
            else
                `CHK(a_out, exp_a.pop_front())
        end
        if (h_oe === 1'b1) begin
            if (exp_h.size() == 0)
                `CHK(h_oe, 1'b0)
            else
                `CHK(h_out, exp_h.pop_front())
        end
        if (m_oe === 1'b1) begin
            if (exp_m.size() == 0)
                `CHK(m_oe, 1'b0)
            else begin
                `CHK(mp_out, par(exp_m[0]))
                `CHK(m_out, exp_m.pop_front())
            end
            `CHK(mp_oe, 1'b1)
        end
    end

    task automatic issue(input ldb_pkg::ldb_cmd_t c, input logic hit);
        int k;
        k = 0;
        cmd_valid <= 1'b1;
        cmd_code <= c;
        cmd_l2_hit <= hit;
        do begin
            @(posedge core_clk);
            k++;
        end while (cmd_ready !== 1'b1 && k < 100);
        cmd_valid <= 1'b0;
    endtask

    task automatic wait_done(input int lim, output logic seen);
        seen = 1'b0;
        for (int i = 0; i < lim && !seen; i++) begin
            @(posedge core_clk);
            seen = (cmd_done === 1'b1);
        end
    endtask

    task automatic run(input ldb_pkg::ldb_cmd_t c, input logic hit);
        logic seen;
        issue(c, hit);
        wait_done(300, seen);
        `CHK(seen, 1'b1)
    endtask

    task automatic tend(input string name);
        repeat (100) @(posedge core_clk);
        `CHK(exp_a.size() + exp_m.size() + exp_h.size(), 0)
        $display("test %s done", name);
    endtask

    task automatic push_dw(input logic [63:0] v);
        exp_a.push_back(v[31:0]);
        exp_a.push_back(v[63:32]);
    endtask

    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge core_clk);
        errors++;
        $display("[ERR] %0t: run did not finish", $time);
        test_done();
    end

    initial begin
        logic seen;
        logic [63:0] v;
        nrst = 1'b0;
        cmd_valid = 1'b0;
        cmd_code = ldb_pkg::CMD_HOST_WR_MEM;
        cmd_l2_hit = 1'b0;
        pci_free = 1'b0;
        h_in = 64'h0123_4567_89ab_cdef;
        m_in = 64'h0000_0000_0000_0000;
        mp_in = 8'h00;
        a_in = 32'h1357_9bdf;
        repeat (4) @(posedge core_clk);
        `CHK({h_oe, m_oe, a_oe, perr_n}, 4'h1)
        `CHK({lnk.hp_ready, lnk.hm_ready, cmd_ready}, 3'h6)
        repeat (4) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (2) @(posedge core_clk);
        for (int i = 0; i < 4; i++)
            exp_m.push_back(h_in + H_STEP * 64'(i));
        run(ldb_pkg::CMD_HOST_WR_MEM, 1'b0);
        tend("host write memory");
        for (int b = 0; b < 2; b++) begin
            m_in <= M_VAL;
            mp_in <= par(M_VAL) ^ {7'h00, b[0]};
            exp_h.push_back(M_VAL);
            run(ldb_pkg::CMD_HOST_RD_MEM, 1'b0);
            `CHK(perr_n, ~b[0])
        end
        mp_in <= par(M_VAL);
        push_dw(M_VAL);
        run(ldb_pkg::CMD_PCI_RD_MEM, 1'b0);
        `CHK(perr_n, 1'b0)
        push_dw(h_in);
        run(ldb_pkg::CMD_PCI_RD_L2, 1'b0);
        for (int hit = 0; hit < 2; hit++) begin
            exp_m.push_back({a_in + A_STEP, a_in});
            if (hit == 1)
                exp_h.push_back({a_in + A_STEP, a_in});
            run(ldb_pkg::CMD_PCI_WR_MEM, hit[0]);
        end
        tend("reads and PCI writes");
        push_dw(h_in);
        run(ldb_pkg::CMD_HOST_WR_PCI, 1'b0);
        exp_h.push_back({a_in + A_STEP, a_in});
        issue(ldb_pkg::CMD_HOST_RD_PCI, 1'b0);
        wait_done(40, seen);
        `CHK(seen, 1'b0)
        pci_free <= 1'b1;
        wait_done(300, seen);
        `CHK(seen, 1'b1)
        tend("host read of PCI");
        pci_free <= 1'b0;
        for (int i = 1; i < 10; i++) begin
            v = H_STEP * 64'(i);
            h_in <= v;
            push_dw(v);
            if (i < 9)
                run(ldb_pkg::CMD_HOST_WR_PCI, 1'b0);
        end
        `CHK(lnk.hp_ready, 1'b0)
        issue(ldb_pkg::CMD_HOST_WR_PCI, 1'b0);
        wait_done(40, seen);
        `CHK(seen, 1'b0)
        pci_free <= 1'b1;
        wait_done(300, seen);
        `CHK(seen, 1'b1)
        tend("posted buffer full");
        pci_free <= 1'b0;
        v = 64'h5a5a_0f0f_a5a5_f0f0;
        h_in <= v;
        push_dw(v);
        issue(ldb_pkg::CMD_HOST_WR_IO, 1'b0);
        wait_done(40, seen);
        `CHK(seen, 1'b0)
        pci_free <= 1'b1;
        wait_done(300, seen);
        #1;
        `CHK({seen, exp_a.size() == 0}, 2'h3)
        tend("io write");
        test_done();
    end
endmodule
`undef CHK
`default_nettype wire
